// ---- src/phy_ctrl_pkg.sv ----
// Shared constants and types for the phy control-pin block.
package phy_ctrl_pkg;
   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam longint CLK_HZ = 50_000_000;
   localparam longint LPS_MIN_HZ = 220_000;
   localparam longint LPS_MAX_HZ = 5_500_000;
   // Longest legal pulse period rounds down, shortest rounds up.
   localparam int LPS_MAX_PERIOD_CYC = int'(CLK_HZ / LPS_MIN_HZ);
   localparam int LPS_MIN_PERIOD_CYC = int'((CLK_HZ + LPS_MAX_HZ - 1) / LPS_MAX_HZ);
   localparam longint SYS_CLK_HZ = 49_152_000;
   localparam longint LINKON_HZ = 6_114_000;
   localparam int NCO_W = 16;
   localparam longint NCO_FULL = 65536;
   localparam logic [NCO_W-1:0] SYS_CLK_INC =
      NCO_W'((SYS_CLK_HZ * NCO_FULL + CLK_HZ / 2) / CLK_HZ);
   // The link-on square wave toggles twice per period.
   localparam logic [NCO_W-1:0] LINKON_INC =
      NCO_W'((2 * LINKON_HZ * NCO_FULL + CLK_HZ / 2) / CLK_HZ);
   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] SELF_ID_OFS = 4'h8;
   localparam logic [3:0] REQ_COUNT_OFS = 4'hc;
   localparam int CTRL_LINKON_BIT = 0;
   localparam int CTRL_FORCE_OFF_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int SELF_ID_PC_LSB = 21;
   localparam logic [31:0] SELF_ID_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [20:0] zero;
      logic [2:0] power_class;
      logic test_two;
      logic test_one;
      logic manager_capable;
      logic link_on_active;
      logic iso_high;
      logic power_down;
      logic cable_inactive;
      logic link_powered;
   } status_s;
endpackage : phy_ctrl_pkg

// ---- src/lps_sense.sv ----
// Link power sense detector: pulse frequency window and steady-high level.
`timescale 1ns/1ps
`default_nettype none
module lps_sense #(
   parameter int MIN_PERIOD = phy_ctrl_pkg::LPS_MIN_PERIOD_CYC,
   parameter int MAX_PERIOD = phy_ctrl_pkg::LPS_MAX_PERIOD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic sense_pin,
   output logic active
);
   // ------------------------------------------------------------------
   // Synchroniser and period counter
   // ------------------------------------------------------------------
   initial begin
      if (MIN_PERIOD < 2 || MAX_PERIOD <= MIN_PERIOD || MAX_PERIOD > 254) begin
         $error("lps_sense: period bounds unusable");
      end
   end
   localparam logic [7:0] MIN_C = 8'(MIN_PERIOD);
   localparam logic [7:0] MAX_C = 8'(MAX_PERIOD);
   logic sync1_q, sync2_q, last_q;
   logic [7:0] cnt_q;
   logic rise;
   always_ff @(posedge aclk) begin
      sync1_q <= sense_pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
   end
   assign rise = sync2_q && !last_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         cnt_q <= 8'h00;
      end else if (rise) begin
         cnt_q <= 8'h01;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // A pulse train counts only inside the frequency window.
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         active <= 1'b0;
      end else if (rise) begin
         active <= (cnt_q >= MIN_C) && (cnt_q <= MAX_C);
      end else if (cnt_q > MAX_C) begin
         // No edge for a full longest period: the level decides.
         active <= sync2_q;
      end
   end
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_fast_pulse_rejected;
      @(posedge aclk) disable iff (!aresetn)
      (rise && enable && cnt_q < MIN_C && cnt_q != 8'h00) |=> !active;
   endproperty
   a_fast_pulse_rejected: assert property (p_fast_pulse_rejected)
      else $error("Too fast sense pulse taken as active.");
   property p_steady_high;
      @(posedge aclk) disable iff (!aresetn)
      (enable && sync2_q && !rise && cnt_q > MAX_C) |=> active;
   endproperty
   a_steady_high: assert property (p_steady_high)
      else $error("Steady high sense not taken as powered.");
   c_pulse_active: cover property (@(posedge aclk) disable iff (!aresetn)
      rise && !active ##1 active);
endmodule : lps_sense
`default_nettype wire

// ---- src/phy_control_pins.sv ----
// Control-pin logic of the phy facing the link controller, with AXI4-Lite registers.
// Notes on behaviour
// - Pulsed link power sense counts as active only between 220 kHz and 5.5 MHz.
// - With link power sense inactive the link interface is disabled; repeating goes on.
// - The link controller asks for service on the request input and the phy accepts it; this design accepts it only while the link interface is enabled.
// - The three power-class straps are copied into self-id packet bits 21 to 23.
// - Power-down high stops all logic except the cable-inactive monitor; this design keeps the AXI4-Lite slave and bus reset drive running.
// - While reset is low a bus reset is driven on every active cable port.
// - Reset returns all control logic to its defined start state.
// - A 49.152 MHz system clock is driven to the link controller for all transfers.
// - Only bus-holder or no isolation with isolation select high is supported.
// - Cable-inactive is high when no port sees an active remote port, even in power-down.
// - A received link-on message is signalled by a 6.114 MHz wave on the linkon pin.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module phy_control_pins #(
   parameter int ADDR_W = 4,
   parameter int PORTS = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_power_sense,
   input wire logic link_service_request,
   input wire logic [2:0] power_class_straps,
   input wire logic power_down_input,
   input wire logic iso_select_n,
   input wire logic factory_test_select_one,
   input wire logic factory_test_select_two,
   input wire logic [PORTS-1:0] port_remote_active,
   input wire logic link_on_message,
   input wire logic manager_capable_linkon_i,
   output logic manager_capable_linkon_o,
   output logic manager_capable_linkon_oe,
   output logic cable_inactive_flag,
   output logic link_side_clock,
   output logic link_interface_enable,
   output logic service_request,
   output logic [PORTS-1:0] bus_reset_drive,
   output logic [31:0] self_id_quadlet
);
   initial begin
      if (ADDR_W < 4 || PORTS < 1) begin
         $error("phy_control_pins: unusable parameters");
      end
   end
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   localparam int SW = PORTS + 9;
   logic [SW-1:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge aclk) begin
      pin_s1_q <= {port_remote_active, power_class_straps, power_down_input, iso_select_n,
                   factory_test_select_one, factory_test_select_two, link_service_request,
                   manager_capable_linkon_i};
      pin_s2_q <= pin_s1_q;
   end
   logic [PORTS-1:0] port_s;
   logic [2:0] straps_s;
   logic pd_s, iso_s, test_one_s, test_two_s, req_s, mgr_s;
   assign {port_s, straps_s, pd_s, iso_s, test_one_s, test_two_s, req_s, mgr_s} = pin_s2_q;

   // ------------------------------------------------------------------
   // Link power and interface enable
   // ------------------------------------------------------------------
   logic lps_active;
   logic [1:0] ctrl_q;
   lps_sense u_lps (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(!pd_s),
      .sense_pin(link_power_sense),
      .active(lps_active)
   );
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_interface_enable <= 1'b0;
      end else begin
         // Only the isolation-select-high style is served; low keeps it shut.
         link_interface_enable <= lps_active && iso_s && !pd_s
                                  && !ctrl_q[phy_ctrl_pkg::CTRL_FORCE_OFF_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Service requests
   // ------------------------------------------------------------------
   logic req_last_q;
   logic [31:0] req_count_q;
   logic req_rise;
   assign req_rise = req_s && !req_last_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_last_q <= 1'b0;
         service_request <= 1'b0;
         req_count_q <= 32'h0000_0000;
      end else begin
         req_last_q <= req_s;
         service_request <= req_rise && link_interface_enable;
         if (req_rise && link_interface_enable) begin
            req_count_q <= req_count_q + 32'h0000_0001;
         end
      end
   end

   // ------------------------------------------------------------------
   // Self-id, cable-inactive and bus reset
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         self_id_quadlet <= phy_ctrl_pkg::SELF_ID_RESET;
      end else if (!pd_s) begin
         self_id_quadlet <= phy_ctrl_pkg::SELF_ID_RESET
                            | (32'(straps_s) << phy_ctrl_pkg::SELF_ID_PC_LSB);
      end
   end
   // The monitor ignores power-down so the link can still learn of a cable.
   always_ff @(posedge aclk) begin
      cable_inactive_flag <= (port_s == '0);
   end
   logic in_reset_q;
   always_ff @(posedge aclk) begin
      in_reset_q <= !aresetn;
   end
   assign bus_reset_drive = in_reset_q ? port_s : '0;

   // ------------------------------------------------------------------
   // System clock and link-on wave
   // ------------------------------------------------------------------
   localparam int NCO_W = phy_ctrl_pkg::NCO_W;
   // The system clock leaves as a one-cycle enable at the 49.152 MHz mean rate.
   function automatic logic [NCO_W:0] nco_step(input logic [NCO_W-1:0] acc,
                                                  input logic [NCO_W-1:0] inc);
      nco_step = {1'b0, acc} + {1'b0, inc};
   endfunction : nco_step
   logic [NCO_W-1:0] sys_acc_q, lkon_acc_q;
   logic [NCO_W:0] sys_next, lkon_next;
   logic link_on_q, wave_q, ctrl_linkon_pulse;
   assign sys_next = nco_step(sys_acc_q, phy_ctrl_pkg::SYS_CLK_INC);
   assign lkon_next = nco_step(lkon_acc_q, phy_ctrl_pkg::LINKON_INC);
   always_ff @(posedge aclk) begin
      if (!aresetn || pd_s) begin
         sys_acc_q <= '0;
         link_side_clock <= 1'b0;
      end else begin
         sys_acc_q <= sys_next[NCO_W-1:0];
         link_side_clock <= sys_next[NCO_W];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || pd_s) begin
         link_on_q <= 1'b0;
         lkon_acc_q <= '0;
         wave_q <= 1'b0;
      end else begin
         if (link_on_message || ctrl_linkon_pulse) begin
            link_on_q <= 1'b1;
         end else if (lps_active) begin
            link_on_q <= 1'b0;
         end
         lkon_acc_q <= link_on_q ? lkon_next[NCO_W-1:0] : '0;
         wave_q <= link_on_q ? (wave_q ^ lkon_next[NCO_W]) : 1'b0;
      end
   end
   assign manager_capable_linkon_o = wave_q;
   assign manager_capable_linkon_oe = link_on_q;

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   logic aw_held_q, w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   phy_ctrl_pkg::status_s status;
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign ctrl_linkon_pulse = do_write && aw_addr_q[3:0] == phy_ctrl_pkg::CTRL_OFS
                              && w_strb_q[0] && w_data_q[phy_ctrl_pkg::CTRL_LINKON_BIT];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= phy_ctrl_pkg::RESP_OKAY;
         ctrl_q <= phy_ctrl_pkg::CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= phy_ctrl_pkg::RESP_OKAY;
            if (aw_addr_q[3:0] == phy_ctrl_pkg::CTRL_OFS && aw_addr_q[ADDR_W-1:2] < 4) begin
               if (w_strb_q[0]) begin
                  ctrl_q <= {w_data_q[phy_ctrl_pkg::CTRL_FORCE_OFF_BIT], 1'b0};
               end
            end else if (aw_addr_q[3:0] > phy_ctrl_pkg::REQ_COUNT_OFS
                         || aw_addr_q[1:0] != 2'h0 || (ADDR_W > 4 && aw_addr_q >> 4 != 0)) begin
               s_axi_bresp <= phy_ctrl_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign status = '{zero: '0, power_class: straps_s, test_two: test_two_s,
                     test_one: test_one_s, manager_capable: mgr_s && !link_on_q,
                     link_on_active: link_on_q, iso_high: iso_s, power_down: pd_s,
                     cable_inactive: cable_inactive_flag, link_powered: lps_active};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= phy_ctrl_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= phy_ctrl_pkg::RESP_OKAY;
         if ((ADDR_W > 4 && s_axi_araddr >> 4 != 0) || s_axi_araddr[1:0] != 2'h0) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= phy_ctrl_pkg::RESP_SLVERR;
         end else if (s_axi_araddr[3:0] == phy_ctrl_pkg::CTRL_OFS) begin
            s_axi_rdata <= {30'h0, ctrl_q};
         end else if (s_axi_araddr[3:0] == phy_ctrl_pkg::STATUS_OFS) begin
            s_axi_rdata <= status;
         end else if (s_axi_araddr[3:0] == phy_ctrl_pkg::SELF_ID_OFS) begin
            s_axi_rdata <= self_id_quadlet;
         end else begin
            s_axi_rdata <= req_count_q;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_no_power_no_link;
      !lps_active |=> !link_interface_enable;
   endproperty
   a_no_power_no_link: assert property (p_no_power_no_link)
      else $error("Link interface enabled without link power.");
   property p_request_taken;
      (req_rise && link_interface_enable) |=> service_request ##1 !service_request;
   endproperty
   a_request_taken: assert property (p_request_taken)
      else $error("Link service request not accepted.");
   property p_straps_in_self_id;
      !pd_s && $past(!pd_s) && $past(aresetn)
         |-> self_id_quadlet[23:21] == $past(power_class_straps, 3);
   endproperty
   a_straps_in_self_id: assert property (p_straps_in_self_id)
      else $error("Power class field does not follow the straps.");
   property p_power_down_quiet;
      pd_s |=> !link_side_clock && !manager_capable_linkon_oe && !link_interface_enable;
   endproperty
   a_power_down_quiet: assert property (p_power_down_quiet)
      else $error("Logic still active in power-down.");
   property p_bus_reset;
      @(posedge aclk) disable iff (1'b0)
      !aresetn && in_reset_q |=> bus_reset_drive == port_s && ctrl_q == phy_ctrl_pkg::CTRL_RESET;
   endproperty
   a_bus_reset: assert property (p_bus_reset)
      else $error("Reset did not drive bus reset or clear control.");
   property p_clock_runs;
      !pd_s [*3] |-> link_side_clock || $past(link_side_clock);
   endproperty
   a_clock_runs: assert property (p_clock_runs)
      else $error("System clock enable missing.");
   property p_iso_low_off;
      !iso_s |=> !link_interface_enable;
   endproperty
   a_iso_low_off: assert property (p_iso_low_off)
      else $error("Interface enabled with isolation select low.");
   property p_cable_inactive;
      cable_inactive_flag == ($past(port_remote_active, 3) == '0);
   endproperty
   a_cable_inactive: assert property (p_cable_inactive)
      else $error("Cable-inactive flag wrong.");
   property p_linkon_wave;
      (link_on_message && !pd_s) |=> manager_capable_linkon_oe ##[1:6] manager_capable_linkon_o;
   endproperty
   a_linkon_wave: assert property (p_linkon_wave)
      else $error("Link-on wave not started.");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_request: cover property (service_request);
   c_linkon: cover property (manager_capable_linkon_oe && manager_capable_linkon_o);
endmodule : phy_control_pins
`default_nettype wire

// ---- test/link_ctrl_model.sv ----
// Behavioural link controller driving the power sense and request pins.
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model (
   input wire logic [1:0] mode,
   input wire logic [15:0] half_ns,
   input wire logic req_go,
   output logic link_power_sense,
   output logic link_service_request
);
   // ------------------------------------------------------------------
   // Power sense: 0 low, 1 steady high, 2 pulsed at the given half period.
   // ------------------------------------------------------------------
   initial begin
      link_power_sense = 1'b0;
      // Pin edges sit between clock edges so the sampling never races them.
      #5;
      forever begin
         if (mode == 2'h2) begin
            link_power_sense = 1'b1;
            #(half_ns);
            link_power_sense = 1'b0;
            #(half_ns);
         end else begin
            link_power_sense = (mode == 2'h1);
            #10;
         end
      end
   end
   // A request is held for six cycles so the phy sees a clean level.
   initial link_service_request = 1'b0;
   always @(posedge req_go) begin
      link_service_request = 1'b1;
      #120;
      link_service_request = 1'b0;
   end
endmodule : link_ctrl_model
`default_nettype wire

// ---- test/serial_bus_phy_control_pins_tb.sv ----
// Self-checking bench for the phy control-pin block.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_phy_control_pins_tb;
   `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, self_id_quadlet, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, mode;
   logic link_power_sense, link_service_request, power_down_input, iso_select_n;
   logic factory_test_select_one, factory_test_select_two, link_on_message, req_go;
   logic manager_capable_linkon_i, manager_capable_linkon_o, manager_capable_linkon_oe;
   logic cable_inactive_flag, link_side_clock, link_interface_enable, service_request, mc_strap;
   logic [2:0] power_class_straps, port_remote_active, bus_reset_drive;
   logic [15:0] half_ns;
   int num_errors, tests_run, cyc, clk_cnt, tog_cnt, req_cnt;
   logic prev_o;
   phy_control_pins uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .link_power_sense, .link_service_request,
      .power_class_straps, .power_down_input, .iso_select_n, .factory_test_select_one,
      .factory_test_select_two, .port_remote_active, .link_on_message,
      .manager_capable_linkon_i, .manager_capable_linkon_o, .manager_capable_linkon_oe,
      .cable_inactive_flag, .link_side_clock, .link_interface_enable, .service_request,
      .bus_reset_drive, .self_id_quadlet);
   link_ctrl_model partner (.mode, .half_ns, .req_go, .link_power_sense, .link_service_request);
   // The shared pin shows the link-on wave while driven, else the strap.
   assign manager_capable_linkon_i = manager_capable_linkon_oe ? manager_capable_linkon_o
      : mc_strap;
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ------------------------------------------------------------------
   // Event counters and hang guard.
   // ------------------------------------------------------------------
   always @(posedge aclk) begin
      cyc++;
      clk_cnt += (link_side_clock === 1'b1);
      req_cnt += (service_request === 1'b1);
      tog_cnt += (manager_capable_linkon_o !== prev_o);
      prev_o = manager_capable_linkon_o;
      if (cyc > 60000) begin
         num_errors++;
         wrap_up();
      end
   end
   function automatic logic [31:0] exp_id(input logic [2:0] s);
      return {8'h00, s, 21'h000000};
   endfunction : exp_id
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : wait_cyc
   task automatic zero_counts();
      @(negedge aclk);
      clk_cnt = 0;
      tog_cnt = 0;
      req_cnt = 0;
   endtask : zero_counts
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      `CHK(r, er)
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
      logic ta, tr;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      `CHK(r, er)
      `CHK(d, ev)
   endtask : rd
   task automatic wrap_up();
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // ------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'h73cc));
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {mode, half_ns, req_go, power_down_input, link_on_message, mc_strap} = '0;
      {factory_test_select_one, factory_test_select_two, iso_select_n} = 3'h7;
      power_class_straps = 3'h5;
      port_remote_active = 3'h6;
      {cyc, num_errors, tests_run, prev_o} = '0;
      s_axi_wstrb = 4'hf;
      wait_cyc(10);
      `CHK(bus_reset_drive, port_remote_active)
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wait_cyc(3);
      `CHK(bus_reset_drive, 3'h0)
      rd(phy_ctrl_pkg::CTRL_OFS, 32'h0, 2'h0);
      @(posedge aclk) link_on_message <= 1'b1;
      @(posedge aclk) link_on_message <= 1'b0;
      zero_counts();
      wait_cyc(1000);
      `CHK(manager_capable_linkon_oe, 1'b1)
      `CHK(tog_cnt inside {[242:247]}, 1'b1)
      `CHK(clk_cnt inside {[981:985]}, 1'b1)
      `CHK(link_interface_enable, 1'b0)
      zero_counts();
      req_go <= 1'b1;
      wait_cyc(20);
      `CHK(req_cnt, 0)
      req_go <= 1'b0;
      // Legal pulse rates, the 160 ns link clock (too fast) and a steady level.
      for (int i = 0; i < 4; i++) begin
         mode <= 2'h0;
         wait_cyc(300);
         mode <= (i == 3) ? 2'h1 : 2'h2;
         half_ns <= (i == 0) ? 16'd200 : (i == 1) ? 16'd80 : 16'd1500;
         wait_cyc(700);
         `CHK(link_interface_enable, i != 1)
      end
      zero_counts();
      for (int i = 0; i < 3; i++) begin
         req_go <= 1'b1;
         wait_cyc(10);
         req_go <= 1'b0;
         wait_cyc(4);
      end
      `CHK(req_cnt, 3)
      rd(phy_ctrl_pkg::REQ_COUNT_OFS, 32'h3, 2'h0);
      for (int i = 0; i < 5; i++) begin
         power_class_straps <= 3'($urandom);
         port_remote_active <= (i == 0) ? 3'h0 : 3'($urandom);
         {factory_test_select_one, factory_test_select_two, mc_strap} <= 3'($urandom);
         wait_cyc(6);
         `CHK(self_id_quadlet, exp_id(power_class_straps))
         `CHK(cable_inactive_flag, port_remote_active == 3'h0)
         rd(phy_ctrl_pkg::SELF_ID_OFS, exp_id(power_class_straps), 2'h0);
         rd(phy_ctrl_pkg::STATUS_OFS, {21'h0, power_class_straps, factory_test_select_two,
            factory_test_select_one, mc_strap, 3'h2, port_remote_active == 3'h0,
            1'b1}, 2'h0);
      end
      iso_select_n <= 1'b0;
      wait_cyc(6);
      `CHK(link_interface_enable, 1'b0)
      @(posedge aclk) iso_select_n <= 1'b1;
      wr(4'h2, 32'h2, phy_ctrl_pkg::RESP_SLVERR);
      rd(4'h6, 32'h0, phy_ctrl_pkg::RESP_SLVERR);
      power_down_input <= 1'b1;
      wait_cyc(10);
      zero_counts();
      @(posedge aclk) port_remote_active <= 3'h0;
      wait_cyc(100);
      `CHK(link_interface_enable, 1'b0)
      `CHK(clk_cnt, 0)
      `CHK(cable_inactive_flag, 1'b1)
      @(posedge aclk) power_down_input <= 1'b0;
      wr(phy_ctrl_pkg::CTRL_OFS, 32'h3, 2'h0);
      rd(phy_ctrl_pkg::CTRL_OFS, 32'h2, 2'h0);
      wait_cyc(4);
      `CHK(link_interface_enable, 1'b0)
      `CHK(manager_capable_linkon_oe, 1'b1)
      @(posedge aclk) aresetn <= 1'b0;
      wait_cyc(20);
      @(posedge aclk) aresetn <= 1'b1;
      rd(phy_ctrl_pkg::CTRL_OFS, 32'h0, 2'h0);
      rd(phy_ctrl_pkg::REQ_COUNT_OFS, 32'h0, 2'h0);
      wait_cyc(250);
      `CHK(link_interface_enable, 1'b1)
      wrap_up();
   end
endmodule : serial_bus_phy_control_pins_tb
`default_nettype wire
